// ==== eem_defines.svh ====
// register offsets, field positions, reset values, codes and timing of the
// serial memory master; assumes a 125 MHz system clock
`ifndef EEM_DEFINES_SVH
`define EEM_DEFINES_SVH
`define EEM_DATA_ADDR 8'h9E
`define EEM_CTRL_ADDR 8'h9F
`define EEM_BIT_ERR 7
`define EEM_BIT_BUSY 6
`define EEM_BIT_RXACK 5
`define EEM_BIT_TXACK 4
`define EEM_BIT_WFR 7
`define EEM_BIT_HIZ 5
`define EEM_BIT_RD 4
`define EEM_RST_ERR 1'b0
`define EEM_RST_RXACK 1'b1
`define EEM_RST_TXACK 1'b1
`define EEM_CMD_NOP 4'h0
`define EEM_CMD_RXACK 4'h2
`define EEM_CMD_TX 4'h3
`define EEM_CMD_STOP 4'h5
`define EEM_CMD_RXLAST 4'h6
`define EEM_CMD_START 4'h9
`define EEM_SEL_TWOPIN 2'h1
`define EEM_SEL_WIRE 2'h2
`define EEM_WIRE_MAXBITS 4'h8
`define EEM_SYS_HZ 125000000
`define EEM_TWOPIN_HZ 78000
`define EEM_WIRE_HZ 500000
`define EEM_QTR_CYC (`EEM_SYS_HZ / (4 * `EEM_TWOPIN_HZ))
`define EEM_HALF_CYC (`EEM_SYS_HZ / (2 * `EEM_WIRE_HZ))
`endif

// ==== eem_pkg.sv ====
// types of the serial memory master
// assumes eem_defines.svh carries the numbers
package eem_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COND,
    ST_BYTE,
    ST_WIRE,
    ST_READY
  } eem_state_t;
endpackage

// ==== eem_serial_master.sv ====
// serial memory master: two-pin and three-wire engines behind two registers
// assumes a processor register port on clk_sys and open-drain/tri pads outside
//
// Function
// - Port-select 01 puts the two-pin interface on the clock pad and data pad.
// - Busy stays high during an operation and the completion pulse fires when it falls.
// - Control bit 5 reads 1 when the memory acknowledged the last byte, resetting to 1.
// - After a receive command and busy falling, the data register holds the byte.
// - The serial clock runs at 78 kHz during a byte and idles high between bytes.
// - An undefined command does nothing and sets error bit 7, which resets to 0.
// - Control bit 4 reads 1 once an acknowledge was sent to the memory, resetting to 1.
// - Command 0000 is a no-op that stops the serial clock.
// - Command 0010 receives a byte and then sends an acknowledge.
// - Command 0011 shifts the data register out as a byte and samples the acknowledge.
// - Command 0101 makes a stop condition.
// - Command 0110 receives the final byte and sends no acknowledge.
// - Command 1001 makes a start condition.
// - Port-select 10 gives a 500 kHz three-wire interface on the same pads.
// - In three-wire mode each control write moves up to 8 bits, write or read.
`include "eem_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module eem_serial_master #(
  parameter int QTR_CYC = `EEM_QTR_CYC,
  parameter int HALF_CYC = `EEM_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // processor register port
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // pad routing
  input wire logic [1:0] portSelectField,
  // pads
  output logic clockPadOut,
  output logic clockPadOe,
  input wire logic dataPadIn,
  output logic dataPadOut,
  output logic dataPadOe,
  // completion event
  output logic completionInterrupt
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic isLegal(input logic [3:0] c);
    isLegal = (c == `EEM_CMD_NOP) || (c == `EEM_CMD_RXACK) ||
              (c == `EEM_CMD_TX) || (c == `EEM_CMD_STOP) ||
              (c == `EEM_CMD_RXLAST) || (c == `EEM_CMD_START);
  endfunction

  eem_pkg::eem_state_t state_ff;
  logic [15:0] divCnt_ff;
  logic [1:0] qtr_ff;
  logic [3:0] bitIdx_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shReg_ff;
  logic [7:0] dataReg_ff;
  logic opTx_ff, opAck_ff, opStart_ff, opHiz_ff, opWfr_ff;
  logic errFlag_ff, rxAck_ff, txAck_ff;
  logic sclOut_ff, sdaOut_ff, sdaDrive_ff;
  logic sdaSync1_ff, sdaSync2_ff, sdaSync3_ff;
  logic busyPrev_ff;
  logic busy, tick, twoPin, wire3, ctrlWr, dataWr, lastWire;

  assign twoPin = (portSelectField == `EEM_SEL_TWOPIN);
  assign wire3 = (portSelectField == `EEM_SEL_WIRE);
  assign busy = (state_ff != eem_pkg::ST_IDLE);
  assign ctrlWr = regWr && (regAddr == `EEM_CTRL_ADDR) && !busy;
  assign dataWr = regWr && (regAddr == `EEM_DATA_ADDR) && !busy;
  assign tick = busy && (divCnt_ff == 16'h0000);
  assign lastWire = (bitIdx_ff + 4'h1 == bitCnt_ff);

  // ----------------------------------------------------------------
  // pads and register read
  // ----------------------------------------------------------------
  // pads are released unless one of the two modes owns them
  assign clockPadOut = sclOut_ff;
  assign clockPadOe = twoPin || wire3;
  assign dataPadOut = sdaOut_ff;
  assign dataPadOe = (twoPin || wire3) && sdaDrive_ff;
  assign completionInterrupt = busyPrev_ff && !busy;

  always_comb begin
    regRdata = 8'h00;
    if (regAddr == `EEM_DATA_ADDR) begin
      regRdata = dataReg_ff;
    end else if (regAddr == `EEM_CTRL_ADDR) begin
      regRdata[`EEM_BIT_ERR] = errFlag_ff;
      regRdata[`EEM_BIT_BUSY] = busy;
      regRdata[`EEM_BIT_RXACK] = rxAck_ff;
      regRdata[`EEM_BIT_TXACK] = txAck_ff;
    end
  end

  // ----------------------------------------------------------------
  // data input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sdaSync1_ff <= 1'b1;
      sdaSync2_ff <= 1'b1;
      sdaSync3_ff <= 1'b1;
      busyPrev_ff <= 1'b0;
    end else begin
      sdaSync1_ff <= dataPadIn;
      sdaSync2_ff <= sdaSync1_ff;
      sdaSync3_ff <= sdaSync2_ff;
      busyPrev_ff <= busy;
    end
  end

  // ----------------------------------------------------------------
  // bit-rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      divCnt_ff <= 16'(QTR_CYC - 1);
    end else if (!busy) begin
      // preload the period of the selected mode, else the first wire half runs a quarter long
      divCnt_ff <= wire3 ? 16'(HALF_CYC - 1) : 16'(QTR_CYC - 1);
    end else if (tick) begin
      divCnt_ff <= (state_ff == eem_pkg::ST_WIRE) ? 16'(HALF_CYC - 1)
                                                   : 16'(QTR_CYC - 1);
    end else begin
      divCnt_ff <= divCnt_ff - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // data register and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dataReg_ff <= 8'h00;
    end else if (dataWr) begin
      dataReg_ff <= regWdata;
    end else if (state_ff == eem_pkg::ST_BYTE && tick && qtr_ff == 2'h3 &&
                 bitIdx_ff == 4'h8 && !opTx_ff) begin
      dataReg_ff <= shReg_ff;
    end else if (state_ff == eem_pkg::ST_WIRE && tick && qtr_ff[0] &&
                 lastWire && !opTx_ff) begin
      dataReg_ff <= {shReg_ff[6:0], sdaSync2_ff};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      errFlag_ff <= `EEM_RST_ERR;
    end else if (ctrlWr && twoPin) begin
      errFlag_ff <= !isLegal(regWdata[3:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rxAck_ff <= `EEM_RST_RXACK;
      txAck_ff <= `EEM_RST_TXACK;
    end else if (state_ff == eem_pkg::ST_BYTE && tick && qtr_ff == 2'h3 &&
                 bitIdx_ff == 4'h8) begin
      if (opTx_ff) begin
        rxAck_ff <= !sdaSync2_ff;
      end else begin
        txAck_ff <= opAck_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // qtr_ff steps four quarters per two-pin bit, two halves per wire bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_ff <= eem_pkg::ST_IDLE;
      qtr_ff <= 2'h0;
      bitIdx_ff <= 4'h0;
      bitCnt_ff <= 4'h0;
      shReg_ff <= 8'h00;
      opTx_ff <= 1'b0;
      opAck_ff <= 1'b0;
      opStart_ff <= 1'b0;
      opHiz_ff <= 1'b0;
      opWfr_ff <= 1'b0;
      sclOut_ff <= 1'b1;
      sdaOut_ff <= 1'b0;
      sdaDrive_ff <= 1'b0;
    end else begin
      case (state_ff)
        eem_pkg::ST_IDLE: begin
          qtr_ff <= 2'h0;
          bitIdx_ff <= 4'h0;
          if (ctrlWr && twoPin) begin
            sdaOut_ff <= 1'b0;
            shReg_ff <= dataReg_ff;
            opTx_ff <= (regWdata[3:0] == `EEM_CMD_TX);
            opAck_ff <= (regWdata[3:0] == `EEM_CMD_RXACK);
            opStart_ff <= (regWdata[3:0] == `EEM_CMD_START);
            case (regWdata[3:0])
              `EEM_CMD_NOP: begin
                sclOut_ff <= 1'b1;
              end
              `EEM_CMD_RXACK, `EEM_CMD_TX, `EEM_CMD_RXLAST: begin
                state_ff <= eem_pkg::ST_BYTE;
              end
              `EEM_CMD_STOP, `EEM_CMD_START: begin
                state_ff <= eem_pkg::ST_COND;
              end
              default: begin
                state_ff <= eem_pkg::ST_IDLE;
              end
            endcase
          end else if (ctrlWr && wire3) begin
            sclOut_ff <= 1'b0;
            opTx_ff <= !regWdata[`EEM_BIT_RD];
            opHiz_ff <= regWdata[`EEM_BIT_HIZ];
            opWfr_ff <= regWdata[`EEM_BIT_WFR];
            shReg_ff <= regWdata[`EEM_BIT_RD] ? 8'h00 : dataReg_ff;
            bitCnt_ff <= (regWdata[3:0] > `EEM_WIRE_MAXBITS) ? `EEM_WIRE_MAXBITS
                                                             : regWdata[3:0];
            if (regWdata[3:0] == 4'h0) begin
              sdaDrive_ff <= !regWdata[`EEM_BIT_HIZ];
            end else begin
              state_ff <= eem_pkg::ST_WIRE;
            end
          end else if (twoPin && state_ff == eem_pkg::ST_IDLE && !sclOut_ff) begin
            sclOut_ff <= 1'b1;
          end
        end
        eem_pkg::ST_COND: begin
          if (tick) begin
            qtr_ff <= qtr_ff + 2'h1;
            case (qtr_ff)
              2'h0: sclOut_ff <= 1'b0;
              2'h1: sdaDrive_ff <= !opStart_ff;
              2'h2: sclOut_ff <= 1'b1;
              default: begin
                // data moves only with the clock high here
                sdaDrive_ff <= opStart_ff;
                state_ff <= eem_pkg::ST_IDLE;
              end
            endcase
          end
        end
        eem_pkg::ST_BYTE: begin
          if (tick) begin
            qtr_ff <= qtr_ff + 2'h1;
            case (qtr_ff)
              2'h0: sclOut_ff <= 1'b0;
              2'h1: begin
                if (bitIdx_ff == 4'h8) begin
                  sdaDrive_ff <= !opTx_ff && opAck_ff;
                end else begin
                  sdaDrive_ff <= opTx_ff && !shReg_ff[7];
                end
              end
              2'h2: sclOut_ff <= 1'b1;
              default: begin
                if (bitIdx_ff == 4'h8) begin
                  state_ff <= eem_pkg::ST_IDLE;
                end else begin
                  bitIdx_ff <= bitIdx_ff + 4'h1;
                  shReg_ff <= opTx_ff ? {shReg_ff[6:0], 1'b0}
                                      : {shReg_ff[6:0], sdaSync2_ff};
                end
              end
            endcase
          end
        end
        eem_pkg::ST_WIRE: begin
          if (tick) begin
            qtr_ff <= {1'b0, !qtr_ff[0]};
            if (!qtr_ff[0]) begin
              sclOut_ff <= 1'b0;
              sdaDrive_ff <= opTx_ff;
              sdaOut_ff <= shReg_ff[7];
            end else begin
              sclOut_ff <= 1'b1;
              shReg_ff <= {shReg_ff[6:0], sdaSync2_ff};
              if (lastWire) begin
                // float right after the final rising edge when asked
                sdaDrive_ff <= opTx_ff && !opHiz_ff;
                state_ff <= (opHiz_ff && opWfr_ff) ? eem_pkg::ST_READY
                                                   : eem_pkg::ST_IDLE;
              end else begin
                bitIdx_ff <= bitIdx_ff + 4'h1;
              end
            end
          end
        end
        eem_pkg::ST_READY: begin
          sclOut_ff <= 1'b0;
          // memory signals end of its internal write by raising data
          if (sdaSync2_ff && !sdaSync3_ff) begin
            state_ff <= eem_pkg::ST_IDLE;
          end
        end
        default: state_ff <= eem_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_padRoute;
    !(twoPin || wire3) |-> !clockPadOe && !dataPadOe;
  endproperty
  a_padRoute: assert property (p_padRoute) else $error("pads driven while unselected");

  property p_doneIrq;
    $fell(busy) |-> completionInterrupt && !busy;
  endproperty
  a_doneIrq: assert property (p_doneIrq) else $error("no completion pulse");

  property p_ackSample;
    (state_ff == eem_pkg::ST_BYTE && tick && qtr_ff == 2'h3 && bitIdx_ff == 4'h8
     && opTx_ff) |=> rxAck_ff == !$past(sdaSync2_ff) && !busy;
  endproperty
  a_ackSample: assert property (p_ackSample) else $error("ack not sampled");

  property p_clockIdle;
    (twoPin && !busy && $past(twoPin) && !$past(busy)) |-> sclOut_ff;
  endproperty
  a_clockIdle: assert property (p_clockIdle) else $error("clock low while idle");

  property p_badCmd;
    (ctrlWr && twoPin && !isLegal(regWdata[3:0])) |=> errFlag_ff && !busy;
  endproperty
  a_badCmd: assert property (p_badCmd) else $error("illegal command accepted");

  property p_ackSent;
    (state_ff == eem_pkg::ST_BYTE && bitIdx_ff == 4'h8 && qtr_ff == 2'h2 &&
     !opTx_ff) |-> sdaDrive_ff == opAck_ff;
  endproperty
  a_ackSent: assert property (p_ackSent) else $error("ack drive wrong");

  property p_noop;
    (ctrlWr && twoPin && regWdata[3:0] == `EEM_CMD_NOP) |=> sclOut_ff && !busy;
  endproperty
  a_noop: assert property (p_noop) else $error("no-op left clock running");

  sequence s_condEnd;
    state_ff == eem_pkg::ST_COND && tick && qtr_ff == 2'h3;
  endsequence
  property p_condLevel;
    s_condEnd |=> sclOut_ff && (sdaDrive_ff == $past(opStart_ff)) && !busy;
  endproperty
  a_condLevel: assert property (p_condLevel) else $error("bad start or stop");

  property p_wireStart;
    (ctrlWr && wire3 && regWdata[3:0] != 4'h0) |=> busy [*2];
  endproperty
  a_wireStart: assert property (p_wireStart) else $error("wire transfer not run");

endmodule

`default_nettype wire

// ==== eem_mem_model.sv ====
// behavioural two-pin serial memory seen from the master's pads
// assumes resolved clock and data wires with a pull-up in the bench
`timescale 1ns/10ps
`default_nettype none
module eem_mem_model (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  output logic pullLow,
  // scenario control
  input wire logic rdMode,
  input wire logic ackOn,
  input wire logic [7:0] txByte,
  // observations
  output logic [7:0] rxByte,
  output logic ackGot,
  output var int startCnt,
  output var int stopCnt
);
  int bitCnt;
  int k;
  initial begin
    pullLow = 1'b0;
    rxByte = 8'h00;
    ackGot = 1'b0;
    startCnt = 0;
    stopCnt = 0;
    bitCnt = 0;
  end
  // framing is only recognised while the clock is high
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      startCnt++;
      bitCnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stopCnt++;
    end
  end
  // each bit opens on a clock fall; the ninth is the acknowledge slot
  always @(negedge scl) begin
    k = (bitCnt >= 9) ? 1 : bitCnt + 1;
    bitCnt = k;
    if (rdMode) begin
      pullLow <= (k <= 8) && !txByte[8 - k];
    end else begin
      pullLow <= (k == 9) && ackOn;
    end
  end
  always @(posedge scl) begin
    if (!rdMode && bitCnt >= 1 && bitCnt <= 8) begin
      rxByte <= {rxByte[6:0], sda};
    end else if (rdMode && bitCnt == 9) begin
      ackGot <= !sda;
    end
  end
endmodule
`default_nettype wire

// ==== eem_serial_master_tb.sv ====
// self-checking bench of the serial memory master
// assumes the behavioural memory model and short quarter and half periods
`timescale 1ns/10ps
`default_nettype none
module eem_serial_master_tb;
  logic clk_sys, sys_rst, regWr, rdMode, ackOn;
  logic [7:0] regAddr, regWdata, regRdata, txByte, rxByte, v;
  logic [7:0] wireShift = 8'h00;
  logic [1:0] portSelectField;
  logic clockPadOut, clockPadOe, dataPadOut, dataPadOe, completionInterrupt;
  logic pullLow, ackGot;
  wire logic scl, sda;
  int failures = 0, comparisons = 0, startCnt, stopCnt, sclPer, s;
  realtime lastRise = 0;
  // open-drain data with pull-up; clock pad floats high when released
  assign scl = clockPadOe ? clockPadOut : 1'b1;
  assign sda = ((dataPadOe && !dataPadOut) || pullLow) ? 1'b0 : 1'b1;
  eem_serial_master #(.QTR_CYC(4), .HALF_CYC(3)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
    .portSelectField(portSelectField), .clockPadOut(clockPadOut), .clockPadOe(clockPadOe),
    .dataPadIn(sda), .dataPadOut(dataPadOut), .dataPadOe(dataPadOe),
    .completionInterrupt(completionInterrupt));
  eem_mem_model mem (.scl(scl), .sda(sda), .pullLow(pullLow), .rdMode(rdMode), .ackOn(ackOn),
    .txByte(txByte), .rxByte(rxByte), .ackGot(ackGot), .startCnt(startCnt), .stopCnt(stopCnt));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge scl) begin
    sclPer = int'(($realtime - lastRise) / 8.0);
    lastRise = $realtime;
    wireShift <= {wireShift[6:0], sda};
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    @(posedge clk_sys);
    #1 d = regRdata;
  endtask
  task automatic op(input logic [7:0] cmd, input logic idleClk);
    int n;
    n = 0;
    wr(8'h9F, cmd);
    chk({7'h0, regRdata[6]}, 8'h01);
    while (regRdata[6] !== 1'b0 && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({7'h0, completionInterrupt}, 8'h01);
    @(posedge clk_sys);
    #1 chk({7'h0, completionInterrupt}, 8'h00);
    chk({7'h0, clockPadOut}, {7'h0, idleClk});
  endtask
  task automatic complete_run;
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(8'h9E, v);
    chk(v, 8'h00);
    rd(8'h9F, v);
    chk(v, 8'h30);
    chk({6'h0, clockPadOut, dataPadOe}, 8'h02);
  endtask
  task automatic t_mode;
    wr(8'h9F, 8'h09);
    chk({6'h0, regRdata[6], clockPadOe}, 8'h00);
    @(posedge clk_sys);
    portSelectField <= 2'h1;
    @(posedge clk_sys);
    #1 chk({7'h0, clockPadOe}, 8'h01);
  endtask
  task automatic t_start;
    s = startCnt;
    op(8'h09, 1'b1);
    chk(8'(startCnt - s), 8'h01);
    chk({7'h0, sda}, 8'h00);
  endtask
  task automatic t_tx(input logic [7:0] b, input logic ack);
    ackOn <= ack;
    wr(8'h9E, b);
    op(8'h03, 1'b1);
    chk(rxByte, b);
    chk(8'(sclPer), 8'h10);
    rd(8'h9F, v);
    chk({7'h0, v[5]}, {7'h0, ack});
  endtask
  task automatic t_rx(input logic [7:0] cmd, input logic [7:0] b, input logic ack);
    rdMode <= 1'b1;
    txByte <= b;
    op(cmd, 1'b1);
    rdMode <= 1'b0;
    chk({7'h0, ackGot}, {7'h0, ack});
    rd(8'h9E, v);
    chk(v, b);
    rd(8'h9F, v);
    chk({7'h0, v[4]}, {7'h0, ack});
  endtask
  task automatic t_stop;
    s = stopCnt;
    op(8'h05, 1'b1);
    chk(8'(stopCnt - s), 8'h01);
    chk({6'h0, sda, dataPadOe}, 8'h02);
  endtask
  task automatic t_illegal;
    for (int c = 0; c < 16; c++) begin
      if (!(c inside {0, 2, 3, 5, 6, 9})) begin
        wr(8'h9F, 8'(c));
        rd(8'h9F, v);
        chk({6'h0, v[7:6]}, 8'h02);
      end
    end
    wr(8'h9F, 8'h00);
    rd(8'h9F, v);
    chk({6'h0, v[6], clockPadOut}, 8'h01);
    t_start();
    rd(8'h9F, v);
    chk({7'h0, v[7]}, 8'h00);
    t_stop();
  endtask
  task automatic t_wire;
    ackOn <= 1'b0;
    portSelectField <= 2'h2;
    wr(8'h9E, 8'h96);
    // the wire engine leaves the clock high after its last rising edge
    op(8'h08, 1'b1);
    chk(wireShift, 8'h96);
    chk(8'(sclPer), 8'h06);
    // the memory's bit counter has wrapped, so four clocks fetch the top nibble
    rdMode <= 1'b1;
    txByte <= 8'hA5;
    op(8'h14, 1'b1);
    rdMode <= 1'b0;
    rd(8'h9E, v);
    chk(v, 8'h0A);
    wr(8'h9F, 8'h00);
    chk({6'h0, regRdata[6], dataPadOe}, 8'h01);
    wr(8'h9F, 8'h20);
    chk({6'h0, regRdata[6], dataPadOe}, 8'h00);
  endtask
  initial begin
    sys_rst = 1'b1;
    regWr = 1'b0;
    regAddr = 8'h9F;
    regWdata = 8'h00;
    portSelectField = 2'h0;
    rdMode = 1'b0;
    ackOn = 1'b1;
    txByte = 8'h00;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_mode();
    t_start();
    t_tx(8'hA5, 1'b1);
    t_tx(8'h5A, 1'b0);
    t_start();
    t_rx(8'h02, 8'h3C, 1'b1);
    t_rx(8'h06, 8'hC3, 1'b0);
    t_stop();
    t_illegal();
    t_wire();
    complete_run();
  end
  // a full run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
